//--- src/mwc_map.svh
`ifndef MWC_MAP_SVH
`define MWC_MAP_SVH

// byte offsets on the apb
`define MWC_WIN_OFS 8'h10
`define MWC_CFG_OFS 8'h14
`define MWC_STAT_OFS 8'h20
`define MWC_IEN_OFS 8'h24
`define MWC_ICLR_OFS 8'h28

// configuration fields
`define MWC_HSEL_MSB 2
`define MWC_HSEL_LSB 0
`define MWC_CNTEN_BIT 3
`define MWC_MUX_MSB 6
`define MWC_MUX_LSB 4
`define MWC_ERST_BIT 7

// reset values
`define MWC_CFG_RST 8'h00
`define MWC_HID_RST 6'h00
`define MWC_IRQ_RST 3'h0

// datapath
`define MWC_DELTA_W 11
`define MWC_SLICE_W 6
`define MWC_SHIFT_MAX 3'h5
`define MWC_SLICE_SAT 6'h3F
`define MWC_AXES 3

`endif

//--- src/mwc_pkg.sv
package mwc_pkg;

	typedef enum logic [2:0] {
		MWC_SEL_NONE_LO = 3'h0,
		MWC_SEL_THR_X = 3'h1,
		MWC_SEL_THR_Y = 3'h2,
		MWC_SEL_THR_Z = 3'h3,
		MWC_SEL_NONE_HI = 3'h4,
		MWC_SEL_CNT_X = 3'h5,
		MWC_SEL_CNT_Y = 3'h6,
		MWC_SEL_CNT_Z = 3'h7
	} mwc_hsel_t;

	typedef logic [5:0] mwc_hid_t;
	typedef logic [7:0] mwc_cfg_t;

endpackage

//--- src/mwc_axis.sv
`timescale 1ns/1ps
`include "mwc_map.svh"

module mwc_axis
	import mwc_pkg::*;
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	input wire logic engine_rst,
	// sample
	input wire logic [10:0] delta,
	input wire logic sample_valid,
	// settings
	input wire logic [2:0] slice_sel,
	input wire mwc_hid_t threshold,
	input wire mwc_hid_t count_limit,
	input wire logic count_en,
	// result
	output logic qualified,
	output logic event_pulse
);

	logic [2:0] shift;
	logic [10:0] shifted;
	logic over;
	mwc_hid_t cmp;
	logic hit;
	mwc_hid_t cnt_reg;
	mwc_hid_t cnt_next;
	logic qual_reg;
	logic qual_next;

	// slice pick and clamp
	always_comb
	begin
		shift = (slice_sel > `MWC_SHIFT_MAX) ? `MWC_SHIFT_MAX : slice_sel;
		shifted = delta >> shift;
		over = |shifted[10:6];
		cmp = over ? `MWC_SLICE_SAT : shifted[5:0];
		hit = sample_valid && (cmp >= threshold);
	end

	// event counting
	always_comb
	begin
		cnt_next = cnt_reg;
		qual_next = qual_reg;
		if (engine_rst)
		begin
			cnt_next = `MWC_HID_RST;
			qual_next = 1'b0;
		end
		else if (hit && count_en)
		begin
			if (cnt_reg >= count_limit)
				qual_next = 1'b1;
			else
				cnt_next = cnt_reg + 6'h01;
		end
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_reg <= `MWC_HID_RST;
			qual_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			qual_reg <= qual_next;
		end
	end

	assign qualified = qual_reg;
	assign event_pulse = qual_next && !qual_reg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	a_slice_top: assert property (slice_sel >= 3'h5
		|-> cmp == delta[10:5])
		else $error("top slice not taken");
	a_clamp_sat: assert property (slice_sel == 3'h0 && |delta[10:6]
		|-> cmp == 6'h3F)
		else $error("clamp did not saturate");
	a_qual_count: assert property ($rose(qual_reg)
		|-> $past(cnt_reg) >= $past(count_limit))
		else $error("qualified before count reached");
	a_qual_hit: assert property ($rose(qual_reg)
		|-> $past(hit) && $past(count_en))
		else $error("qualified without enabled hit");
	a_eng_clear: assert property (engine_rst
		|=> !qual_reg && cnt_reg == 6'h00)
		else $error("engine reset did not clear axis");
	c_axis_qual: cover property ($rose(qual_reg));

endmodule

//--- src/mwc_top.sv
// Contract
// - bits 2:0 pick hidden register: 1-3 thresholds, 5-7 counts, 0 and 4 none
// - bit 3 enables detection counters for all axes; cleared by default
// - motion wakeup becomes declared only while counting is enabled; stays declared after counting is disabled, until bit 7 resets the engine
// - bits 6:4 pick delta slice n+5:n; codes 5-7 pick 10:5
// - delta bits above the slice saturate the compared value
// - bit 7 set holds the engine in reset; clear releases it
// - bit 7 keeps its written value; hardware never clears it
// - configuration byte reads zero after power-on; all fields read-write
// - each axis threshold is an independent unsigned six-bit value
// - count register holds wanted events minus one; zero means one event
`timescale 1ns/1ps
`include "mwc_map.svh"

module mwc_top
	import mwc_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// per-axis deltas
	input wire logic [10:0] delta_x,
	input wire logic [10:0] delta_y,
	input wire logic [10:0] delta_z,
	input wire logic delta_valid,
	// engine state
	output logic engine_reset,
	output logic [2:0] axis_qualified,
	output logic wake,
	output logic irq
);

	mwc_cfg_t config_reg;
	mwc_cfg_t config_next;
	mwc_hid_t thr_reg [3];
	mwc_hid_t thr_next [3];
	mwc_hid_t cnt_reg [3];
	mwc_hid_t cnt_next [3];
	logic [2:0] status_reg;
	logic [2:0] status_next;
	logic [2:0] ien_reg;
	logic [2:0] ien_next;
	logic irq_reg;
	logic irq_next;
	logic wake_reg;
	logic wake_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic pready_reg;
	logic pready_next;
	logic pslverr_reg;
	logic pslverr_next;

	logic [10:0] delta_a [3];
	logic [2:0] qual_w;
	logic [2:0] evt_w;
	logic wr_take;
	logic [7:0] addr8;
	logic [2:0] hsel;
	logic [1:0] hidx;
	logic hvalid;
	logic hcount;
	logic [2:0] clr_w;
	mwc_hid_t win_rd;
	logic addr_map;

	assign delta_a[0] = delta_x;
	assign delta_a[1] = delta_y;
	assign delta_a[2] = delta_z;
	assign addr8 = paddr[7:0];

	// hidden register decode
	always_comb
	begin
		hsel = config_reg[`MWC_HSEL_MSB:`MWC_HSEL_LSB];
		hvalid = (hsel[1:0] != 2'h0);
		hcount = hsel[2];
		hidx = hsel[1:0] - 2'h1;
		win_rd = `MWC_HID_RST;
		if (hvalid)
			win_rd = hcount ? cnt_reg[hidx] : thr_reg[hidx];
	end

	// apb handshake: one wait state
	always_comb
	begin
		wr_take = psel && penable && pready_reg && pwrite;
		pready_next = psel && penable && !pready_reg;
		prdata_next = prdata_reg;
		pslverr_next = 1'b0;
		if (pready_next)
		begin
			prdata_next = 32'h0000_0000;
			case (addr8)
				`MWC_WIN_OFS: prdata_next = {26'h0, win_rd};
				`MWC_CFG_OFS: prdata_next = {24'h0, config_reg};
				`MWC_STAT_OFS: prdata_next = {29'h0, status_reg};
				`MWC_IEN_OFS: prdata_next = {29'h0, ien_reg};
				`MWC_ICLR_OFS: prdata_next = 32'h0000_0000;
				default: pslverr_next = 1'b1;
			endcase
		end
	end

	// register writes
	always_comb
	begin
		config_next = config_reg;
		thr_next = thr_reg;
		cnt_next = cnt_reg;
		ien_next = ien_reg;
		clr_w = 3'h0;
		if (wr_take)
		begin
			case (addr8)
				`MWC_CFG_OFS: config_next = pwdata[7:0];
				`MWC_WIN_OFS:
				begin
					if (hvalid && hcount)
						cnt_next[hidx] = pwdata[5:0];
					else if (hvalid)
						thr_next[hidx] = pwdata[5:0];
				end
				`MWC_IEN_OFS: ien_next = pwdata[2:0];
				`MWC_ICLR_OFS: clr_w = pwdata[2:0];
				default: config_next = config_reg;
			endcase
		end
	end

	// sticky status, set wins over clear
	always_comb
	begin
		status_next = (status_reg & ~clr_w) | evt_w;
		irq_next = |(status_reg & ien_reg);
		wake_next = |qual_w;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			config_reg <= `MWC_CFG_RST;
			for (int i = 0; i < `MWC_AXES; i++)
			begin
				thr_reg[i] <= `MWC_HID_RST;
				cnt_reg[i] <= `MWC_HID_RST;
			end
			status_reg <= `MWC_IRQ_RST;
			ien_reg <= `MWC_IRQ_RST;
			irq_reg <= 1'b0;
			wake_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			config_reg <= config_next;
			thr_reg <= thr_next;
			cnt_reg <= cnt_next;
			status_reg <= status_next;
			ien_reg <= ien_next;
			irq_reg <= irq_next;
			wake_reg <= wake_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	// per-axis detection
	genvar g;
	generate
		for (g = 0; g < `MWC_AXES; g++)
		begin : axis
			mwc_axis u_axis (
				.clock(clock),
				.rst_n(rst_n),
				.engine_rst(config_reg[`MWC_ERST_BIT]),
				.delta(delta_a[g]),
				.sample_valid(delta_valid),
				.slice_sel(config_reg[`MWC_MUX_MSB:`MWC_MUX_LSB]),
				.threshold(thr_reg[g]),
				.count_limit(cnt_reg[g]),
				.count_en(config_reg[`MWC_CNTEN_BIT]),
				.qualified(qual_w[g]),
				.event_pulse(evt_w[g])
			);
		end
	endgenerate

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;
	assign engine_reset = config_reg[`MWC_ERST_BIT];
	assign axis_qualified = qual_w;
	assign wake = wake_reg;
	assign irq = irq_reg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	// decoded addresses, for the bus checks
	assign addr_map = (addr8 == `MWC_WIN_OFS) || (addr8 == `MWC_CFG_OFS)
		|| (addr8 == `MWC_STAT_OFS) || (addr8 == `MWC_IEN_OFS)
		|| (addr8 == `MWC_ICLR_OFS);

	// register file checks
	a_cfg_hold: assert property (!(wr_take && addr8 == 8'h14)
		|=> $stable(config_reg))
		else $error("configuration changed without a write");
	a_cfg_write: assert property (wr_take && addr8 == 8'h14
		|=> config_reg == $past(pwdata[7:0]))
		else $error("configuration write lost");
	a_cfg_read: assert property (psel && penable && !pready
		&& !pwrite && addr8 == `MWC_CFG_OFS
		|=> prdata == {24'h0, $past(config_reg)})
		else $error("configuration read wrong");
	a_window_none: assert property (wr_take && addr8 == 8'h10
		&& config_reg[1:0] == 2'h0
		|=> $stable(thr_reg[0]) && $stable(cnt_reg[0]))
		else $error("window wrote with no selection");
	a_window_idle: assert property (wr_take && addr8 == `MWC_WIN_OFS
		&& config_reg[1:0] == 2'h0
		|=> $stable(thr_reg[1]) && $stable(thr_reg[2])
		&& $stable(cnt_reg[1]) && $stable(cnt_reg[2]))
		else $error("window wrote with no selection");
	a_window_empty: assert property (psel && penable && !pready
		&& addr8 == `MWC_WIN_OFS && !hvalid
		|=> prdata == 32'h0000_0000)
		else $error("empty window read not zero");
	a_window_x: assert property (wr_take && addr8 == `MWC_WIN_OFS
		&& config_reg[2:0] == 3'h1
		|=> thr_reg[0] == $past(pwdata[5:0]) && $stable(thr_reg[1])
		&& $stable(thr_reg[2]))
		else $error("x threshold write wrong");
	a_window_thr: assert property (wr_take && addr8 == 8'h10
		&& config_reg[2:0] == 3'h2
		|=> thr_reg[1] == $past(pwdata[5:0]) && $stable(cnt_reg[1]))
		else $error("y threshold write wrong");
	a_window_cnt: assert property (wr_take && addr8 == 8'h10
		&& config_reg[2:0] == 3'h7
		|=> cnt_reg[2] == $past(pwdata[5:0]) && $stable(thr_reg[2]))
		else $error("z count write wrong");

	// engine, interrupt and bus checks
	a_engine_hold: assert property (config_reg[7] [*3]
		|-> axis_qualified == 3'h0 && !wake && engine_reset)
		else $error("engine not held in reset");
	a_qual_gate: assert property (!config_reg[3] && axis_qualified == 3'h0
		|=> axis_qualified == 3'h0)
		else $error("qualified with counting disabled");
	a_qual_sticky: assert property (!engine_reset
		|=> (axis_qualified & $past(axis_qualified))
		== $past(axis_qualified))
		else $error("qualification lost without engine reset");
	a_wake_high: assert property (|axis_qualified |=> wake)
		else $error("wake not raised");
	a_wake_low: assert property (axis_qualified == 3'h0 |=> !wake)
		else $error("wake without qualification");
	a_status_sticky: assert property (|evt_w
		|=> (status_reg & $past(evt_w)) == $past(evt_w))
		else $error("event not recorded");
	a_status_clear: assert property (wr_take && addr8 == `MWC_ICLR_OFS
		&& evt_w == 3'h0
		|=> (status_reg & $past(pwdata[2:0])) == 3'h0)
		else $error("status clear lost");
	a_status_hold: assert property (evt_w == 3'h0
		&& !(wr_take && addr8 == `MWC_ICLR_OFS)
		|=> $stable(status_reg))
		else $error("status changed without cause");
	a_ien_write: assert property (wr_take && addr8 == `MWC_IEN_OFS
		|=> ien_reg == $past(pwdata[2:0]))
		else $error("interrupt enable write lost");
	a_irq_level: assert property (|(status_reg & ien_reg) |=> irq)
		else $error("interrupt not raised");
	a_irq_low: assert property (!(|(status_reg & ien_reg)) |=> !irq)
		else $error("interrupt without enabled status");
	a_apb_ready: assert property (psel && penable && !pready
		|=> pready ##1 !pready)
		else $error("apb ready timing");
	a_unmapped_err: assert property (psel && penable && !pready && !addr_map
		|=> pslverr && prdata == 32'h0000_0000)
		else $error("unmapped access not refused");
	a_mapped_ok: assert property (psel && penable && !pready && addr_map
		|=> !pslverr)
		else $error("mapped access refused");

	c_cfg_write: cover property (wr_take && addr8 == 8'h14);
	c_win_write: cover property (wr_take && addr8 == 8'h10 && hvalid);
	c_wake: cover property ($rose(wake));
	c_irq: cover property ($rose(irq));

endmodule

//--- test/mwc_top_test.sv
`timescale 1ns/1ps
`include "mwc_map.svh"
module mwc_top_test import mwc_pkg::*; ;
	logic clock, rst_n, psel, penable, pwrite, delta_valid;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, engine_reset, wake, irq, er;
	logic [10:0] dx, dy, dz;
	logic [2:0] axis_qualified;
	integer seed, n_errors, cmp_count, cfg, i, j;
	integer thr[3], cnt[3], hits[3], q[3];

	mwc_top u_mwc_top (.clock(clock), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .delta_x(dx), .delta_y(dy), .delta_z(dz),
		.delta_valid(delta_valid), .engine_reset(engine_reset),
		.axis_qualified(axis_qualified), .wake(wake), .irq(irq));

	task finish_test;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e)
		begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
			n_errors++;
		end
	endtask

	// one apb transfer, held until pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'h1;
		do
			@(posedge clock);
		while (pready !== 1'h1);
		rd = prdata;
		er = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clock);
	endtask

	task wcfg(input integer v);
		cfg = v & 255;
		apb(1'h1, `MWC_CFG_OFS, cfg);
		if (cfg[7])
			for (j = 0; j < 3; j++)
			begin
				hits[j] = 0;
				q[j] = 0;
			end
	endtask

	task wwin(input integer s, input integer v);
		wcfg((cfg & 248) | s);
		apb(1'h1, `MWC_WIN_OFS, v);
		if (s > 0 && s < 4)
			thr[s-1] = v & 63;
		if (s > 4)
			cnt[s-5] = v & 63;
	endtask

	task smp(input logic [10:0] x, input logic [10:0] y, input logic [10:0] z);
		integer k, sh, s;
		logic [10:0] d [3];
		d[0] = x;
		d[1] = y;
		d[2] = z;
		dx <= x;
		dy <= y;
		dz <= z;
		delta_valid <= 1'h1;
		@(posedge clock);
		delta_valid <= 1'h0;
		sh = (cfg >> 4) & 7;
		if (sh > 5)
			sh = 5;
		for (k = 0; k < 3; k++)
		begin
			s = d[k] >> sh;
			if (s > 63)
				s = 63;
			if (cfg[3] && !cfg[7] && s >= thr[k])
			begin
				if (hits[k] >= cnt[k])
					q[k] = 1;
				hits[k]++;
			end
		end
		repeat (2) @(posedge clock);
		chk(axis_qualified, {q[2][0], q[1][0], q[0][0]});
		chk(wake, q[0] | q[1] | q[2]);
	endtask

	initial
	begin
		clock = 1'h0;
		forever #5 clock = ~clock;
	end

	initial
	begin
		#300000;
		n_errors++;
		finish_test;
	end

	initial
	begin
		seed = 32'h10BEB41F;
		{n_errors, cmp_count, cfg} = 0;
		{rst_n, psel, penable, pwrite, delta_valid} = 5'h00;
		{paddr, pwdata, dx, dy, dz} = 0;
		for (i = 0; i < 3; i++)
			{thr[i], cnt[i], hits[i], q[i]} = 0;
		repeat (5) @(posedge clock);
		rst_n <= 1'h1;
		@(posedge clock);
		apb(1'h0, `MWC_CFG_OFS, 0);
		chk(rd, 0);
		apb(1'h0, 8'h30, 32'hFFFFFFFF);
		chk({er, rd[30:0]}, 32'h80000000);
		for (i = 0; i < 6; i++)
		begin
			wcfg($random(seed));
			chk(engine_reset, cfg[7]);
			apb(1'h0, `MWC_CFG_OFS, 0);
			chk(rd, cfg);
		end
		wcfg(0);
		for (i = 0; i < 8; i++)
			wwin(i, $random(seed));
		for (i = 0; i < 8; i++)
		begin
			wcfg(i);
			apb(1'h0, `MWC_WIN_OFS, 0);
			chk(rd, (i % 4 == 0) ? 0 : (i < 4 ? thr[i-1] : cnt[i-5]));
		end
		for (i = 0; i < 8; i++)
		begin
			for (j = 1; j < 8; j++)
				wwin(j, j > 4 ? 0 : $random(seed));
			wcfg((i << 4) | 8);
			smp($random(seed), $random(seed), $random(seed));
			wcfg(cfg | 128);
			smp(11'h7FF, 11'h7FF, 11'h7FF);
			chk(engine_reset, 1);
			wcfg(cfg & 127);
		end
		wcfg(0);
		smp(11'h7FF, 11'h7FF, 11'h7FF);
		wwin(1, 0);
		wwin(2, 63);
		wwin(3, 63);
		wwin(5, 2);
		apb(1'h1, `MWC_ICLR_OFS, 7);
		apb(1'h0, `MWC_STAT_OFS, 0);
		chk(rd, 0);
		apb(1'h1, `MWC_IEN_OFS, 7);
		apb(1'h0, `MWC_IEN_OFS, 0);
		chk(rd, 7);
		chk(irq, 0);
		wcfg(8);
		for (i = 0; i < 3; i++)
			smp(11'h001, 11'h000, 11'h000);
		@(posedge clock);
		chk(irq, 1);
		apb(1'h0, `MWC_STAT_OFS, 0);
		chk(rd, 1);
		apb(1'h1, `MWC_ICLR_OFS, 7);
		repeat (2) @(posedge clock);
		chk(irq, 0);
		wcfg(136);
		wcfg(8);
		smp(11'h001, 11'h000, 11'h000);
		finish_test;
	end
endmodule
